// ### rtl/host_bus_pkg.sv
package host_bus_pkg;

    // register pick line values
    localparam logic       PICK_DATA    = 1'h0;
    localparam logic       PICK_CONTROL = 1'h1;

    // first control register field positions
    localparam int         CF_TONE_EN   = 0;
    localparam int         CF_PROGRESS  = 1;
    localparam int         CF_IRQ_EN    = 2;
    localparam int         CF_SEL2      = 3;

    // second control register field positions
    localparam int         CS_BURST_OFF = 0;
    localparam int         CS_TEST      = 1;
    localparam int         CS_SINGLE    = 2;
    localparam int         CS_COLUMN    = 3;

    // status field positions
    localparam int         ST_IRQ       = 0;
    localparam int         ST_TX_READY  = 1;
    localparam int         ST_RX_FULL   = 2;
    localparam int         ST_DSTEER    = 3;

    // reset values
    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [3:0] CODE_RESET   = 4'h0;

    // burst timing: 51 ms tone mode, doubled in progress mode
    localparam int         CLK_MHZ      = 125;
    localparam int         BURST_MS     = 51;
    localparam longint     BURST_CYC    = longint'(BURST_MS) * CLK_MHZ
                                          * 1000;
    localparam int         CNT_W        = 24;

    typedef enum logic [0:0] {
        STYLE_RW_LINE = 1'b0,
        STYLE_STROBES = 1'b1
    } bus_style_t;

    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_TONE  = 2'b01,
        BURST_PAUSE = 2'b10
    } burst_state_t;

    // host-side pins as one carrier
    typedef struct packed {
        logic       cs_n;
        logic       bus_data_strobe;
        logic       rw_wr;
        logic       register_pick_line;
        logic [3:0] data;
    } host_pins_t;

    // transmitter settings toward the tone synthesiser
    typedef struct packed {
        logic       tone_on;
        logic       single;
        logic       column;
        logic [3:0] code;
    } tone_ctrl_t;

endpackage

// ### rtl/adaptive_host_bus_regs.sv
`timescale 1ns/1ns
// Function
// - cs fall with strobe low selects read/write-line bus style
// - cs fall with read strobe high selects separate strobe style
// - one internal select qualifies accesses in every style
// - pick line and data latched at instants suiting the bus type
// - status keeps updating without host strobe activity
// - pick 0 write tx, 0 read rx, 1 write control, 1 read status
// - receive data read-only, last valid digit code
// - transmit data write-only, selects tone pair
// - first control b3 routes next control write to second register
// - interrupt pin only pulls low or floats
// - first control: tone enable, mode, irq enable, second select
// - tone enable low turns all transmit tone functions off
// - mode high call progress, low tone mode
// - progress mode with irq enable: pin follows received tone
// - no digit detection or report in progress mode
// - tone mode irq: pin low on valid digit or tx ready
// - second control: burst off, test, single, column
// - burst low automatic burst and pause then ready; else tone bit
// - single high single tone; column bit picks column or row
// - test in tone mode: pin mirrors delayed steering
// - status: irq, tx ready, rx full, steering; read clears b0-b2
module adaptive_host_bus_regs #(
    parameter logic [23:0] BURST_LEN = 24'(host_bus_pkg::BURST_CYC)
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     srst_i,
    input  wire host_bus_pkg::host_pins_t pins_i,
    output logic [3:0]                    data_o,
    output logic                          data_oe_n_o,
    output logic                          irq_tone_pin_n_o,
    output logic                          irq_tone_oe_n_o,
    input  wire logic                     digit_valid_i,
    input  wire logic [3:0]               digit_code_i,
    input  wire logic                     steering_i,
    input  wire logic                     progress_tone_i,
    output host_bus_pkg::tone_ctrl_t      tone_o,
    output logic                          progress_mode_o,
    output logic                          test_mode_o
);

    // three-stage synchronisers on host pins
    logic [2:0] cs_s;
    logic [2:0] ds_s;
    logic [2:0] rw_s;
    logic [2:0] pk_s;
    logic [3:0] d_s1;
    logic [3:0] d_s2;
    logic [3:0] d_s3;
    always_ff @(posedge ref_clk_i) begin
        cs_s <= {cs_s[1:0], pins_i.cs_n};
        ds_s <= {ds_s[1:0], pins_i.bus_data_strobe};
        rw_s <= {rw_s[1:0], pins_i.rw_wr};
        pk_s <= {pk_s[1:0], pins_i.register_pick_line};
        d_s1 <= pins_i.data;
        d_s2 <= d_s1;
        d_s3 <= d_s2;
    end

    // a change counts once stages two and three agree
    logic       cs_r;
    logic       ds_r;
    logic       rw_r;
    logic       pk_r;
    logic [3:0] d_r;
    logic       cs_fall;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cs_r <= 1'b1;
            ds_r <= 1'b1;
            rw_r <= 1'b1;
            pk_r <= host_bus_pkg::PICK_DATA;
            d_r  <= host_bus_pkg::CODE_RESET;
        end else begin
            if (cs_s[1] == cs_s[2]) cs_r <= cs_s[2];
            if (ds_s[1] == ds_s[2]) ds_r <= ds_s[2];
            if (rw_s[1] == rw_s[2]) rw_r <= rw_s[2];
            if (pk_s[1] == pk_s[2]) pk_r <= pk_s[2];
            if (d_s2 == d_s3) d_r <= d_s3; // whole nibble must agree
        end
    end
    assign cs_fall = cs_r && (cs_s[1] == cs_s[2]) && !cs_s[2];

    // bus style sensed at each chip select fall
    host_bus_pkg::bus_style_t style_r;
    logic                     pick_r;
    logic                     cs_active_r;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            style_r     <= host_bus_pkg::STYLE_RW_LINE;
            pick_r      <= host_bus_pkg::PICK_DATA;
            cs_active_r <= 1'b0;
        end else if (cs_fall) begin
            // strobe low: rw-line style; read strobe high: strobes
            style_r <= ds_s[2] ? host_bus_pkg::STYLE_STROBES
                               : host_bus_pkg::STYLE_RW_LINE;
            pick_r      <= pk_r;
            cs_active_r <= 1'b1;
        end else if (cs_r) begin
            cs_active_r <= 1'b0;
        end
    end

    // equivalent internal select: read and write windows
    logic rd_win;
    logic wr_win;
    logic acc_win;
    logic acc_prev_r;
    logic acc_is_rd_r;
    logic acc_end;
    always_comb begin
        if (style_r == host_bus_pkg::STYLE_RW_LINE) begin
            // strobe high marks the data phase, rw high reads
            rd_win = ds_r && rw_r;
            wr_win = ds_r && !rw_r;
        end else begin
            // active-low separate strobes
            rd_win = !ds_r;
            wr_win = !rw_r;
        end
    end
    assign acc_win = !cs_r && (rd_win || wr_win);
    assign acc_end = acc_prev_r && !acc_win;

    // remember kind of access; write data latched at window close
    logic [3:0] wdata_r;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            acc_prev_r  <= 1'b0;
            acc_is_rd_r <= 1'b0;
            wdata_r     <= host_bus_pkg::CODE_RESET;
        end else begin
            acc_prev_r <= acc_win;
            if (acc_win) begin
                acc_is_rd_r <= rd_win;
                wdata_r     <= d_r;
            end
        end
    end

    // separate buses: pick line taken as the access window opens
    logic pick_win_r;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pick_win_r <= host_bus_pkg::PICK_DATA;
        end else if (acc_win && !acc_prev_r) begin
            pick_win_r <= pk_r;
        end
    end

    // multiplexed bus: address valid only at the chip select fall
    logic pick_now;
    always_comb begin
        if (!cs_active_r)
            pick_now = pk_r;
        else if (style_r == host_bus_pkg::STYLE_STROBES)
            pick_now = pick_r;
        else if (acc_prev_r)
            pick_now = pick_win_r;
        else
            pick_now = pk_r;
    end

    logic wr_tx;
    logic wr_ctl;
    logic rd_stat;
    assign wr_tx   = acc_end && !acc_is_rd_r
                     && pick_now == host_bus_pkg::PICK_DATA;
    assign wr_ctl  = acc_end && !acc_is_rd_r
                     && pick_now == host_bus_pkg::PICK_CONTROL;
    assign rd_stat = acc_end && acc_is_rd_r
                     && pick_now == host_bus_pkg::PICK_CONTROL;

    // control registers sharing one address
    logic [3:0] control_first_r;
    logic [3:0] control_second_r;
    logic       to_second_r;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            control_first_r  <= host_bus_pkg::CTRL_RESET;
            control_second_r <= host_bus_pkg::CTRL_RESET;
            to_second_r      <= 1'b0;
        end else if (wr_ctl) begin
            if (to_second_r) begin
                control_second_r <= wdata_r;
                to_second_r      <= 1'b0;
            end else begin
                control_first_r <= wdata_r;
                to_second_r     <= wdata_r[host_bus_pkg::CF_SEL2];
            end
        end
    end

    logic tone_en;
    logic prog_mode;
    logic irq_en;
    logic burst_off;
    assign tone_en   = control_first_r[host_bus_pkg::CF_TONE_EN];
    assign prog_mode = control_first_r[host_bus_pkg::CF_PROGRESS];
    assign irq_en    = control_first_r[host_bus_pkg::CF_IRQ_EN];
    assign burst_off = control_second_r[host_bus_pkg::CS_BURST_OFF];

    // transmit code register, write only
    logic [3:0] tone_code_out_r;
    logic       tx_load;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tone_code_out_r <= host_bus_pkg::CODE_RESET;
        end else if (wr_tx) begin
            tone_code_out_r <= wdata_r;
        end
    end
    assign tx_load = wr_tx;

    // burst sequencer: tone then equal pause, doubled in progress mode
    host_bus_pkg::burst_state_t burst_st_r;
    logic [host_bus_pkg::CNT_W:0] burst_cnt_r;
    logic [host_bus_pkg::CNT_W:0] burst_len;
    logic                         burst_done;
    logic                         burst_tone;
    assign burst_len = prog_mode ? {BURST_LEN, 1'b0} : {1'b0, BURST_LEN};
    assign burst_done = burst_cnt_r >= burst_len - 25'h0000001;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || burst_off || !tone_en) begin
            burst_st_r  <= host_bus_pkg::BURST_IDLE;
            burst_cnt_r <= '0;
        end else begin
            case (burst_st_r)
                host_bus_pkg::BURST_IDLE: begin
                    burst_cnt_r <= '0;
                    if (tx_load) burst_st_r <= host_bus_pkg::BURST_TONE;
                end
                host_bus_pkg::BURST_TONE: begin
                    burst_cnt_r <= burst_done ? '0
                                              : burst_cnt_r + 25'h0000001;
                    if (burst_done)
                        burst_st_r <= host_bus_pkg::BURST_PAUSE;
                end
                host_bus_pkg::BURST_PAUSE: begin
                    burst_cnt_r <= burst_done ? '0
                                              : burst_cnt_r + 25'h0000001;
                    if (burst_done) burst_st_r <= host_bus_pkg::BURST_IDLE;
                end
                default: begin
                    burst_st_r <= host_bus_pkg::BURST_IDLE;
                end
            endcase
        end
    end
    assign burst_tone = burst_st_r == host_bus_pkg::BURST_TONE;
    logic tx_ready_evt;
    assign tx_ready_evt = !burst_off && tone_en && burst_done
                          && burst_st_r == host_bus_pkg::BURST_PAUSE;

    // receive digit capture, suppressed in progress mode
    logic [3:0] digit_code_in_r;
    logic       rx_evt;
    assign rx_evt = digit_valid_i && !prog_mode;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            digit_code_in_r <= host_bus_pkg::CODE_RESET;
        end else if (rx_evt) begin
            digit_code_in_r <= digit_code_i;
        end
    end

    // sticky status flags; set wins over read clear
    logic flag_irq_r;
    logic flag_txr_r;
    logic flag_rxf_r;
    logic irq_evt;
    assign irq_evt = rx_evt || tx_ready_evt;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            flag_irq_r <= 1'b0;
            flag_txr_r <= 1'b0;
            flag_rxf_r <= 1'b0;
        end else begin
            // internal events update without host activity
            if (irq_evt) flag_irq_r <= 1'b1;
            else if (rd_stat) flag_irq_r <= 1'b0;
            if (tx_ready_evt) flag_txr_r <= 1'b1;
            else if (rd_stat || burst_off) flag_txr_r <= 1'b0;
            if (rx_evt) flag_rxf_r <= 1'b1;
            else if (rd_stat) flag_rxf_r <= 1'b0;
        end
    end

    logic [3:0] status;
    always_comb begin
        status = '0;
        status[host_bus_pkg::ST_IRQ]      = flag_irq_r;
        status[host_bus_pkg::ST_TX_READY] = flag_txr_r;
        status[host_bus_pkg::ST_RX_FULL]  = flag_rxf_r;
        status[host_bus_pkg::ST_DSTEER]   = steering_i;
    end

    // read data driven during the read window
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            data_o      <= '0;
            data_oe_n_o <= 1'b1;
        end else begin
            data_oe_n_o <= !(acc_win && rd_win);
            data_o      <= (pick_now == host_bus_pkg::PICK_CONTROL)
                           ? status : digit_code_in_r;
        end
    end

    // interrupt/progress pin, open drain
    logic test_mode;
    logic pull_low;
    assign test_mode = control_second_r[host_bus_pkg::CS_TEST];
    always_comb begin
        if (prog_mode)
            pull_low = irq_en && !progress_tone_i;
        else if (test_mode)
            pull_low = !steering_i;
        else
            pull_low = irq_en && flag_irq_r;
    end
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) irq_tone_oe_n_o <= 1'b1;
        else irq_tone_oe_n_o <= !pull_low;
    end
    assign irq_tone_pin_n_o = 1'b0;

    // transmitter settings
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tone_o <= '0;
        end else begin
            tone_o.tone_on <= burst_off ? tone_en : burst_tone;
            tone_o.single  <= control_second_r[host_bus_pkg::CS_SINGLE];
            tone_o.column  <= control_second_r[host_bus_pkg::CS_COLUMN];
            tone_o.code    <= tone_code_out_r;
        end
    end
    assign progress_mode_o = prog_mode;
    assign test_mode_o     = test_mode;

endmodule

// ### tb/adaptive_host_bus_regs_checker.sv
`timescale 1ns/1ns
module adaptive_host_bus_regs_checker #(
    parameter logic [23:0] BURST_LEN = 24'h000014
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     srst_i,
    input  wire host_bus_pkg::host_pins_t pins_i,
    input  wire logic                     data_oe_n_o,
    input  wire logic                     irq_tone_pin_n_o,
    input  wire logic                     irq_tone_oe_n_o,
    input  wire logic                     steering_i,
    input  wire logic                     progress_tone_i,
    input  wire host_bus_pkg::tone_ctrl_t tone_o,
    input  wire logic                     progress_mode_o,
    input  wire logic                     test_mode_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // outputs idle right after reset release
    property p_reset_vals;
        $fell(srst_i) |-> data_oe_n_o && irq_tone_oe_n_o && tone_o == '0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs not idle after reset");
    // open drain pin never driven high
    property p_pin_drive;
        irq_tone_pin_n_o == 1'b0;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("interrupt pin driven high");
    // no data drive without chip select
    property p_idle_float;
        pins_i.cs_n [*8] |-> data_oe_n_o;
    endproperty
    a_idle_float: assert property (p_idle_float)
        else $error("data driven while deselected");
    // writes never turn the data bus around
    property p_write_float;
        (!pins_i.rw_wr) [*8] |-> data_oe_n_o;
    endproperty
    a_write_float: assert property (p_write_float)
        else $error("data driven during write");
    // tone code changes only through host writes
    property p_code_hold;
        pins_i.cs_n [*8] |-> $stable(tone_o.code);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("tone code changed without access");
    // control fields change only through host writes
    property p_ctrl_hold;
        pins_i.cs_n [*8] |-> $stable({progress_mode_o, test_mode_o,
                                      tone_o.single, tone_o.column});
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control changed without access");
    // progress mode pin floats while tone level is high
    property p_progress_float;
        (progress_mode_o && progress_tone_i) [*6] |-> irq_tone_oe_n_o;
    endproperty
    a_progress_float: assert property (p_progress_float)
        else $error("pin low with progress tone high");
    // test mode pin mirrors delayed steering
    property p_test_mirror;
        (test_mode_o && !progress_mode_o && $stable(steering_i)) [*6]
            |-> irq_tone_oe_n_o == steering_i;
    endproperty
    a_test_mirror: assert property (p_test_mirror)
        else $error("pin does not follow steering");
    // main scenarios reached
    c_read_drive: cover property ($fell(data_oe_n_o));
    c_pin_low: cover property ($fell(irq_tone_oe_n_o));
    c_tone_on: cover property ($rose(tone_o.tone_on));
endmodule

// ### tb/host_cpu_model.sv
`timescale 1ns/1ns
module host_cpu_model (
    input  wire logic                ref_clk_i,
    input  wire logic [3:0]          data_o,
    input  wire logic                data_oe_n_o,
    output host_bus_pkg::host_pins_t pins_o
);
    // idle bus: deselected, strobes inactive
    initial pins_o = '{1'b1, 1'b0, 1'b1, 1'b0, 4'h0};
    // one access; strobes high picks separate read/write strobe style
    task automatic access(input logic s, input logic pick, input logic wr,
                          input logic [3:0] wdata, output logic [3:0] rdata);
        @(posedge ref_clk_i);
        pins_o.bus_data_strobe    <= s;
        pins_o.rw_wr              <= s ? 1'b1 : !wr;
        pins_o.register_pick_line <= pick;
        pins_o.data               <= wdata;
        repeat (2) @(posedge ref_clk_i);
        pins_o.cs_n <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        if (s && wr) pins_o.rw_wr <= 1'b0;
        else pins_o.bus_data_strobe <= !s;
        repeat (10) @(posedge ref_clk_i);
        rdata = data_oe_n_o ? 4'hz : data_o;
        pins_o.rw_wr           <= s ? 1'b1 : !wr;
        pins_o.bus_data_strobe <= s;
        repeat (4) @(posedge ref_clk_i);
        pins_o.cs_n <= 1'b1;
        pins_o.data <= ~wdata; // released lines do not keep old value
        repeat (10) @(posedge ref_clk_i);
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    localparam logic [23:0] BURST_SIM = 24'h000014;
    logic                     ref_clk_i       = 1'b0;
    logic                     srst_i          = 1'b1;
    logic                     digit_valid_i   = 1'b0;
    logic                     steering_i      = 1'b0;
    logic                     progress_tone_i = 1'b1;
    logic [3:0]               digit_code_i    = 4'h0;
    host_bus_pkg::host_pins_t pins;
    logic [3:0]               data_o;
    logic                     data_oe_n_o;
    logic                     irq_tone_pin_n_o;
    logic                     irq_tone_oe_n_o;
    logic                     progress_mode_o;
    logic                     test_mode_o;
    host_bus_pkg::tone_ctrl_t tone_o;
    logic [3:0]               rd;
    int                       bad_count  = 0;
    int                       n_compared = 0;
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin \
    bad_count++; $display("FAIL %0t got %h want %h", $time, act, exp); end end
    // free running clock
    always #4 ref_clk_i = ~ref_clk_i;
    adaptive_host_bus_regs #(.BURST_LEN(BURST_SIM)) adaptive_host_bus_regs_i (
        .ref_clk_i, .srst_i, .pins_i(pins), .data_o, .data_oe_n_o,
        .irq_tone_pin_n_o, .irq_tone_oe_n_o, .digit_valid_i, .digit_code_i,
        .steering_i, .progress_tone_i, .tone_o, .progress_mode_o,
        .test_mode_o);
    host_cpu_model host_cpu_model_i (
        .ref_clk_i, .data_o, .data_oe_n_o, .pins_o(pins));
    // register helpers
    task automatic wr(input logic s, input logic p, input logic [3:0] v);
        host_cpu_model_i.access(s, p, 1'b1, v, rd);
    endtask
    task automatic rdchk(input logic s, input logic p, input logic [3:0] e);
        host_cpu_model_i.access(s, p, 1'b0, 4'h0, rd);
        `CHK(rd, e)
    endtask
    task automatic digit(input logic [3:0] c);
        @(posedge ref_clk_i);
        digit_code_i  <= c;
        digit_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        digit_valid_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // reset state and start-up sequence
    task automatic t_reset;
        `CHK({data_oe_n_o, irq_tone_oe_n_o}, 2'h3)
        `CHK(tone_o, 7'h00)
        `CHK(irq_tone_pin_n_o, 1'h0)
        rdchk(1'b0, 1'b1, 4'h0);
        wr(1'b0, 1'b1, 4'h0);
        wr(1'b0, 1'b1, 4'h0);
        wr(1'b0, 1'b1, 4'h8);
        wr(1'b0, 1'b1, 4'h0);
        rdchk(1'b0, 1'b1, 4'h0);
    endtask
    // control routing and transmit settings, read/write-line style
    task automatic t_regs;
        wr(1'b0, 1'b1, 4'h8);
        wr(1'b0, 1'b1, 4'h5);
        `CHK({tone_o.single, tone_o.column}, 2'h2)
        wr(1'b0, 1'b0, 4'h7);
        wr(1'b0, 1'b1, 4'h1);
        `CHK({tone_o.tone_on, tone_o.code}, 5'h17)
        `CHK({progress_mode_o, test_mode_o}, 2'h0)
        rdchk(1'b0, 1'b0, 4'h0);
        wr(1'b0, 1'b1, 4'h0);
        `CHK(tone_o.tone_on, 1'b0)
    endtask
    // strobe style writes and reads, receive path and status
    task automatic t_strobe_rx;
        wr(1'b1, 1'b1, 4'h8);
        wr(1'b1, 1'b1, 4'hc);
        `CHK({tone_o.single, tone_o.column}, 2'h3)
        digit(4'ha);
        steering_i <= 1'b1;
        rdchk(1'b1, 1'b0, 4'ha);
        rdchk(1'b1, 1'b1, 4'hd);
        rdchk(1'b0, 1'b1, 4'h8);
        steering_i <= 1'b0;
    endtask
    // interrupt and progress mode on the open drain pin
    task automatic t_pin;
        wr(1'b0, 1'b1, 4'h4);
        digit(4'h3);
        `CHK(irq_tone_oe_n_o, 1'b0)
        rdchk(1'b0, 1'b1, 4'h5);
        `CHK(irq_tone_oe_n_o, 1'b1)
        wr(1'b0, 1'b1, 4'h6);
        `CHK(progress_mode_o, 1'b1)
        progress_tone_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        `CHK(irq_tone_oe_n_o, 1'b0)
        progress_tone_i <= 1'b1;
        digit(4'h9);
        rdchk(1'b0, 1'b1, 4'h0);
    endtask
    // burst then pause then transmitter ready; test mode mirror
    task automatic t_burst_test;
        wr(1'b0, 1'b1, 4'h1);
        wr(1'b0, 1'b0, 4'h2);
        `CHK(tone_o.code, 4'h2)
        `CHK(tone_o.tone_on, 1'h1)
        repeat (60) @(posedge ref_clk_i);
        `CHK(tone_o.tone_on, 1'h0)
        rdchk(1'b0, 1'b1, 4'h3);
        rdchk(1'b0, 1'b1, 4'h0);
        wr(1'b0, 1'b1, 4'h8);
        wr(1'b0, 1'b1, 4'h2);
        `CHK(test_mode_o, 1'h1)
        steering_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        `CHK(irq_tone_oe_n_o, 1'b1)
        steering_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        `CHK(irq_tone_oe_n_o, 1'b0)
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        t_reset();
        t_regs();
        t_strobe_rx();
        t_pin();
        t_burst_test();
        final_report();
    end
    // watchdog against a hang
    initial begin
        repeat (8000) @(posedge ref_clk_i);
        bad_count++;
        final_report();
    end
endmodule
bind adaptive_host_bus_regs adaptive_host_bus_regs_checker #(
    .BURST_LEN(BURST_LEN)) adaptive_host_bus_regs_checker_i (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins_i(pins_i),
    .data_oe_n_o(data_oe_n_o), .irq_tone_pin_n_o(irq_tone_pin_n_o),
    .irq_tone_oe_n_o(irq_tone_oe_n_o), .steering_i(steering_i),
    .progress_tone_i(progress_tone_i), .tone_o(tone_o),
    .progress_mode_o(progress_mode_o), .test_mode_o(test_mode_o));
